// >>> verilog/bmps_map.svh
// constants of the burst-mode and protection sequencer: times, counts, offsets, fields
// assumes a 100 MHz core clock; times are converted to cycles here
`ifndef BMPS_MAP_SVH
`define BMPS_MAP_SVH

`define BMPS_CLK_HZ 100000000
`define BMPS_MS_CYC(t) ((t) * (`BMPS_CLK_HZ / 1000))
`define BMPS_US_CYC(t) ((t) * (`BMPS_CLK_HZ / 1000000))
// least times round up to whole cycles
`define BMPS_NS_CYC(t) (((t) * (`BMPS_CLK_HZ / 1000000) + 999) / 1000)

`define BMPS_ENTRY_BLANK_MS 24
`define BMPS_OVERLOAD_BLANK_MS 30
`define BMPS_SS_STEP_MS 3
`define BMPS_VCC_OV_US 10
`define BMPS_OUT_OV_US 100
`define BMPS_SHORT_WIND_NS 190
`define BMPS_MAX_ON_US 30
`define BMPS_BURST_RATE_HZ 52000
`define BMPS_BURST_DUTY_PCT 50

`define BMPS_BURST_PER_CYC (`BMPS_CLK_HZ / `BMPS_BURST_RATE_HZ)
`define BMPS_BURST_ON_CYC (`BMPS_BURST_PER_CYC * `BMPS_BURST_DUTY_PCT / 100)

`define BMPS_ENTRY_COUNT 3'h7
`define BMPS_EXIT_COUNT 3'h1
`define BMPS_SS_LAST 2'h3

`define BMPS_CTRL_OFS 4'h0
`define BMPS_STATUS_OFS 4'h4
`define BMPS_CAUSE_OFS 4'h8

`define BMPS_CTRL_EN_BIT 0
`define BMPS_CTRL_RST 1'h1

`define BMPS_STAT_STATE_LSB 0
`define BMPS_STAT_BURST_BIT 2
`define BMPS_STAT_RUN_BIT 3
`define BMPS_STAT_GATE_BIT 4
`define BMPS_STAT_START_BIT 5
`define BMPS_STAT_SS_LSB 6

// cause flags: undervolt, supply ov, overload, overtemp, output ov, short winding
`define BMPS_CAUSE_W 6
`define BMPS_CAUSE_RST 6'h00

`endif

// >>> verilog/bmps_pkg.sv
// types of the burst-mode and protection sequencer
// assumes nothing beyond the map header
package bmps_pkg;
  typedef enum logic [1:0] {st_off, st_run, st_latch} bmps_state_t;
endpackage

// >>> verilog/bmps_top.sv
// burst-mode and protection sequencer with an avalon-mm register slave
// assumes comparator inputs already synchronous to clk and a valley counter outside
//
// Overview of operation
// - burst entry needs light-load feedback and valley counter equal to seven
// - entry conditions must hold unbroken for 24 ms before burst is set
// - paused burst resumes switching and bias when resume comparator asserts
// - burst turn-on comes from a fixed 52 kHz timer
// - burst turn-off on burst current trip or at half the timer period
// - pause comparator drops bias and stops switching until resume
// - exit comparator leaves burst at once and restores full current limit
// - leaving burst forces the valley counter to one immediately
// - supply under- or overvoltage resets control and holds the switch off
// - after supply reaches turn-on level again, run starts with fresh soft-start
// - supply overvoltage must last 10 us and counts only outside burst
// - feedback overload lasting 30 ms restarts; ignored in burst
// - overtemperature restarts, except in burst where it is ignored
// - output overvoltage during off-time latches off after 100 us
// - latch-off is released only by supply below power-down level
// - short-winding current during on-time latches off after 190 ns; not in burst
// - latched off: switch off, startup cell toggles with supply thresholds
// - gate high longer than maximum on-time is turned off at once
// - maximum on-time is 30 us
// - soft-start raises regulation level one step every 3 ms
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`include "bmps_map.svh"

module bmps_persist #(
  parameter int W = 22,
  parameter logic [W-1:0] N = '1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cond,
  output logic hit
);
  logic [W-1:0] cnt_reg;

  // any drop of cond restarts the count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else if (!cond) begin
      cnt_reg <= '0;
    end else if (cnt_reg != N) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign hit = cond && (cnt_reg == N);
endmodule // bmps_persist

module bmps_top import bmps_pkg::*; #(
  parameter int ENTRY_BLANK_CYC = `BMPS_MS_CYC(`BMPS_ENTRY_BLANK_MS),
  parameter int OVERLOAD_BLANK_CYC = `BMPS_MS_CYC(`BMPS_OVERLOAD_BLANK_MS),
  parameter int SS_STEP_CYC = `BMPS_MS_CYC(`BMPS_SS_STEP_MS),
  parameter int OUT_OV_CYC = `BMPS_US_CYC(`BMPS_OUT_OV_US)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic burst_entry_feedback_level,
  input wire logic burst_resume_feedback_level,
  input wire logic burst_pause_feedback_level,
  input wire logic burst_exit_feedback_level,
  input wire logic feedback_overload,
  input wire logic burst_peak_current_level,
  input wire logic peak_current_trip,
  input wire logic short_winding_current_level,
  input wire logic output_overvoltage_level,
  input wire logic controller_overtemp_level,
  input wire logic supply_turn_off_level,
  input wire logic supply_turn_on_level,
  input wire logic supply_power_down_level,
  input wire logic supply_overvoltage,
  input wire logic [2:0] valley_count,
  input wire logic normal_turn_on,
  output logic gate_drive,
  output logic bias_enable,
  output logic full_current_limit,
  output logic startup_enable,
  output logic valley_force_one,
  output logic [2:0] valley_force_value,
  output logic [1:0] soft_start_step,
  output logic burst_mode
);
  localparam int MAX_ON_CYC = `BMPS_US_CYC(`BMPS_MAX_ON_US);
  localparam int SW_CYC = `BMPS_NS_CYC(`BMPS_SHORT_WIND_NS);
  localparam int VCC_OV_CYC = `BMPS_US_CYC(`BMPS_VCC_OV_US);
  localparam logic [10:0] BURST_LAST = 11'(`BMPS_BURST_PER_CYC - 1);
  localparam logic [10:0] BURST_ON = 11'(`BMPS_BURST_ON_CYC);
  localparam logic [11:0] ON_LAST = 12'(MAX_ON_CYC - 1);
  localparam logic [21:0] SS_LAST_CYC = 22'(SS_STEP_CYC - 1);

  bmps_state_t state_reg;
  logic ctrl_en_reg;
  logic [`BMPS_CAUSE_W-1:0] cause_reg;
  logic [`BMPS_CAUSE_W-1:0] cause_set;
  logic [`BMPS_CAUSE_W-1:0] cause_clr;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic gate_reg;
  logic bias_reg;
  logic full_lim_reg;
  logic startup_reg;
  logic force_reg;
  logic burst_reg;
  logic burst_run_reg;
  logic [10:0] btmr_reg;
  logic [11:0] on_cnt_reg;
  logic [21:0] ss_cnt_reg;
  logic [1:0] ss_step_reg;
  logic running;
  logic ss_done;
  logic entry_cond;
  logic entry_hit;
  logic ov_hit;
  logic olp_hit;
  logic ovp_hit;
  logic sw_hit;
  logic ot_hit;
  logic latch_req;
  logic ar_req;
  logic gate_ok;
  logic gate_off;
  logic gate_on;
  logic bus_req;
  logic bus_wr;

  assign running = (state_reg == st_run);
  assign ss_done = (ss_step_reg == `BMPS_SS_LAST);

  // qualification timers
  assign entry_cond = running && ss_done && !burst_reg && burst_entry_feedback_level
    && (valley_count == `BMPS_ENTRY_COUNT);

  bmps_persist #(.W(22), .N(22'(ENTRY_BLANK_CYC))) u_entry (
    .clk(clk), .arst_n(arst_n), .cond(entry_cond), .hit(entry_hit));

  bmps_persist #(.W(22), .N(22'(VCC_OV_CYC))) u_vcc_ov (
    .clk(clk), .arst_n(arst_n), .cond(supply_overvoltage && !burst_reg), .hit(ov_hit));

  bmps_persist #(.W(22), .N(22'(OVERLOAD_BLANK_CYC))) u_olp (
    .clk(clk), .arst_n(arst_n), .cond(feedback_overload && !burst_reg), .hit(olp_hit));

  // output overvoltage only counts while the switch is off
  bmps_persist #(.W(22), .N(22'(OUT_OV_CYC))) u_out_ov (
    .clk(clk), .arst_n(arst_n), .cond(output_overvoltage_level && !gate_reg),
    .hit(ovp_hit));

  bmps_persist #(.W(22), .N(22'(SW_CYC))) u_sw (
    .clk(clk), .arst_n(arst_n),
    .cond(short_winding_current_level && gate_reg && !burst_reg), .hit(sw_hit));

  assign ot_hit = controller_overtemp_level && !burst_reg;
  assign latch_req = running && (ovp_hit || sw_hit);
  assign ar_req = running && (supply_turn_off_level || ov_hit || olp_hit || ot_hit);

  // operating state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= st_off;
    end else begin
      unique case (state_reg)
        st_off: begin
          // restart only after a full charge cycle of the supply
          if (startup_reg && supply_turn_on_level) begin
            state_reg <= st_run;
          end
        end
        st_run: begin
          if (latch_req) begin
            state_reg <= st_latch;
          end else if (ar_req) begin
            state_reg <= st_off;
          end
        end
        st_latch: begin
          if (supply_power_down_level) begin
            state_reg <= st_off;
          end
        end
      endcase
    end
  end

  // startup cell hysteresis, active in every state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_reg <= 1'b1;
    end else if (supply_turn_on_level) begin
      startup_reg <= 1'b0;
    end else if (supply_turn_off_level) begin
      startup_reg <= 1'b1;
    end
  end

  // soft-start stepping, restarted on every entry to run
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ss_cnt_reg <= '0;
      ss_step_reg <= '0;
    end else if (!running) begin
      ss_cnt_reg <= '0;
      ss_step_reg <= '0;
    end else if (!ss_done) begin
      if (ss_cnt_reg == SS_LAST_CYC) begin
        ss_cnt_reg <= '0;
        ss_step_reg <= ss_step_reg + 2'h1;
      end else begin
        ss_cnt_reg <= ss_cnt_reg + 22'h00_0001;
      end
    end
  end

  // burst mode flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_reg <= 1'b0;
    end else if (!running || burst_exit_feedback_level) begin
      burst_reg <= 1'b0;
    end else if (entry_hit) begin
      burst_reg <= 1'b1;
    end
  end

  // valley counter load pulse on any burst exit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      force_reg <= 1'b0;
    end else begin
      force_reg <= burst_reg && (!running || burst_exit_feedback_level);
    end
  end

  // burst switching pause and resume; entry starts paused
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_run_reg <= 1'b0;
    end else if (!running || !burst_reg || burst_exit_feedback_level) begin
      burst_run_reg <= 1'b0;
    end else if (burst_pause_feedback_level) begin
      burst_run_reg <= 1'b0;
    end else if (burst_resume_feedback_level) begin
      burst_run_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bias_reg <= 1'b0;
      full_lim_reg <= 1'b1;
    end else begin
      bias_reg <= running && (!burst_reg || burst_run_reg);
      full_lim_reg <= !burst_reg;
    end
  end

  // fixed-rate burst timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      btmr_reg <= '0;
    end else if (!burst_run_reg || btmr_reg == BURST_LAST) begin
      btmr_reg <= '0;
    end else begin
      btmr_reg <= btmr_reg + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_cnt_reg <= '0;
    end else if (!gate_reg) begin
      on_cnt_reg <= '0;
    end else begin
      on_cnt_reg <= on_cnt_reg + 12'h001;
    end
  end

  // gate drive
  assign gate_ok = running && ctrl_en_reg && !latch_req && !ar_req;
  assign gate_off = (on_cnt_reg == ON_LAST)
    || (burst_reg ? (burst_peak_current_level || btmr_reg == BURST_ON)
                  : peak_current_trip);
  assign gate_on = burst_reg ? (burst_run_reg && btmr_reg == 11'h000)
                             : normal_turn_on;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_reg <= 1'b0;
    end else if (!gate_ok) begin
      gate_reg <= 1'b0;
    end else if (gate_reg) begin
      gate_reg <= !gate_off;
    end else begin
      gate_reg <= gate_on;
    end
  end

  // bus slave: one wait cycle, then the access completes
  assign bus_req = avs_read || avs_write;
  assign bus_wr = avs_write && !wait_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en_reg <= `BMPS_CTRL_RST;
    end else if (bus_wr && avs_address == `BMPS_CTRL_OFS && avs_byteenable[0]) begin
      ctrl_en_reg <= avs_writedata[`BMPS_CTRL_EN_BIT];
    end
  end

  // causes are sticky; a new event beats a write-one clear
  assign cause_set = {sw_hit, ovp_hit, ot_hit, olp_hit, ov_hit, supply_turn_off_level}
    & {`BMPS_CAUSE_W{running}};
  assign cause_clr = (bus_wr && avs_address == `BMPS_CAUSE_OFS && avs_byteenable[0])
    ? avs_writedata[`BMPS_CAUSE_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_reg <= `BMPS_CAUSE_RST;
    end else begin
      cause_reg <= (cause_reg & ~cause_clr) | cause_set;
    end
  end

  always_comb begin
    rdata_next = '0;
    unique case (avs_address)
      `BMPS_CTRL_OFS: rdata_next[`BMPS_CTRL_EN_BIT] = ctrl_en_reg;
      `BMPS_STATUS_OFS: begin
        rdata_next[`BMPS_STAT_STATE_LSB +: 2] = state_reg;
        rdata_next[`BMPS_STAT_BURST_BIT] = burst_reg;
        rdata_next[`BMPS_STAT_RUN_BIT] = burst_run_reg;
        rdata_next[`BMPS_STAT_GATE_BIT] = gate_reg;
        rdata_next[`BMPS_STAT_START_BIT] = startup_reg;
        rdata_next[`BMPS_STAT_SS_LSB +: 2] = ss_step_reg;
      end
      `BMPS_CAUSE_OFS: rdata_next[`BMPS_CAUSE_W-1:0] = cause_reg;
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign gate_drive = gate_reg;
  assign bias_enable = bias_reg;
  assign full_current_limit = full_lim_reg;
  assign startup_enable = startup_reg;
  assign valley_force_one = force_reg;
  assign valley_force_value = `BMPS_EXIT_COUNT; // constant, needs no flop
  assign soft_start_step = ss_step_reg;
  assign burst_mode = burst_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  burst_entry_gate_a: assert property ($rose(burst_reg) |-> $past(entry_cond))
    else $error("burst set without entry conditions");
  entry_blank_a: assert property ($rose(burst_reg) |-> $past(entry_cond, 2))
    else $error("burst set without held entry conditions");
  burst_resume_a: assert property (burst_reg && !burst_run_reg && running
    && burst_resume_feedback_level && !burst_pause_feedback_level
    && !burst_exit_feedback_level |=> burst_run_reg ##1 bias_reg)
    else $error("burst did not resume");
  burst_turn_on_a: assert property (running && ctrl_en_reg && burst_run_reg && burst_reg
    && !gate_reg && btmr_reg == 11'h000 && !latch_req && !ar_req |=> gate_reg)
    else $error("burst timer did not start the gate");
  burst_duty_a: assert property (burst_reg && gate_reg && btmr_reg == BURST_ON
    |=> !gate_reg)
    else $error("burst duty limit exceeded");
  burst_pause_a: assert property (burst_reg && burst_pause_feedback_level
    |=> !burst_run_reg ##1 !bias_reg)
    else $error("burst did not pause");
  burst_exit_a: assert property (burst_reg && burst_exit_feedback_level
    |=> !burst_reg ##1 full_lim_reg)
    else $error("burst exit not immediate");
  valley_force_a: assert property ($fell(burst_reg) |-> force_reg)
    else $error("valley counter not forced on burst exit");
  supply_fault_a: assert property (running && supply_turn_off_level
    |=> !gate_reg && state_reg != st_run)
    else $error("undervoltage did not stop the switch");
  latch_hold_a: assert property (state_reg == st_latch && !supply_power_down_level
    |=> state_reg == st_latch && !gate_reg)
    else $error("latch released early");
  max_on_a: assert property (gate_reg && on_cnt_reg == ON_LAST |=> !gate_reg)
    else $error("maximum on-time exceeded");
  latch_prio_a: assert property (latch_req && ar_req |=> state_reg == st_latch)
    else $error("auto-restart beat latch-off");
endmodule // bmps_top

// >>> tb/bmps_partner.sv
// partner: gate driver, burst current comparator and valley counter
// assumes gate_drive and the force pulse come from the sequencer on clk
module bmps_partner (
  input wire logic clk,
  input wire logic gate_drive,
  input wire logic valley_force_one,
  input wire logic [2:0] valley_force_value,
  input wire logic load_req,
  input wire logic [2:0] load_val,
  input wire logic [11:0] trip_after,
  output logic [2:0] valley_count,
  output logic burst_peak_current_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] on_cyc;
  // valley counter stays unknown until the bench loads it; entry is gated off until then
  always @(posedge clk) begin
    if (load_req) begin
      valley_count <= load_val;
    end else if (valley_force_one) begin
      valley_count <= valley_force_value;
    end
    on_cyc <= gate_drive ? on_cyc + 12'h001 : 12'h000;
  end
  // current ramps only while gate is high; zero means no trip at all
  assign burst_peak_current_level = gate_drive && trip_after != 12'h000 && on_cyc >= trip_after;
endmodule // bmps_partner

// >>> tb/tb_bmps_top.sv
// testbench of the burst-mode and protection sequencer
// assumes bmps_top with shortened counts and the partner model beside it
module tb_bmps_top import bmps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EB = 50;
  localparam int SS = 20;
  logic clk, arst_n, rd, wr, wq, ent, res, pau, ext, ovl, bpc, swc, oov, otp, soff, son, spd, sov;
  logic nto, gate, bias, fcl, sue, vfo, bm, ld;
  logic [3:0] adr;
  logic [31:0] wd, rdd, q;
  logic [2:0] vc, vfv, lv;
  logic [1:0] ssp;
  logic [11:0] trip;
  logic [15:0] seed;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int len;
  bmps_top #(.ENTRY_BLANK_CYC(EB), .OVERLOAD_BLANK_CYC(60), .SS_STEP_CYC(SS), .OUT_OV_CYC(40))
  dut_u (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdd), .avs_waitrequest(wq),
    .burst_entry_feedback_level(ent), .burst_resume_feedback_level(res),
    .burst_pause_feedback_level(pau), .burst_exit_feedback_level(ext),
    .feedback_overload(ovl), .burst_peak_current_level(bpc), .peak_current_trip(1'b0),
    .short_winding_current_level(swc), .output_overvoltage_level(oov),
    .controller_overtemp_level(otp), .supply_turn_off_level(soff),
    .supply_turn_on_level(son), .supply_power_down_level(spd), .supply_overvoltage(sov),
    .valley_count(vc), .normal_turn_on(nto), .gate_drive(gate), .bias_enable(bias),
    .full_current_limit(fcl), .startup_enable(sue), .valley_force_one(vfo),
    .valley_force_value(vfv), .soft_start_step(ssp), .burst_mode(bm));
  bmps_partner part_u (.clk(clk), .gate_drive(gate), .valley_force_one(vfo),
    .valley_force_value(vfv), .load_req(ld), .load_val(lv), .trip_after(trip),
    .valley_count(vc), .burst_peak_current_level(bpc));
  always #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // half of the burst timer period, in cycles
  function automatic int duty_cyc();
    return (100000000 / 52000) * 50 / 100;
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return gate;
      1: return bm;
      default: return bias;
    endcase
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    // only the cycle ceiling ends a wait that never comes
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_on(input int k, input logic v, input int n);
    for (int t = 0; t < n && sig(k) !== v; t++) @(posedge clk);
    #1;
  endtask
  task automatic pulse_len();
    len = 0;
    wait_on(0, 1'b1, 3000);
    while (gate === 1'b1 && len < 4000) begin
      step(1);
      len++;
    end
  endtask
  task automatic state_is(input logic [1:0] s);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("state", s, q[1:0]);
  endtask
  // undervoltage then turn-on: the only way back to run after a restart
  task automatic restart();
    @(posedge clk);
    son <= 1'b0;
    soff <= 1'b1;
    step(3);
    chk("startup on", 1'b1, sue);
    @(posedge clk);
    soff <= 1'b0;
    son <= 1'b1;
    step(3);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    {clk, arst_n, rd, wr, ent, res, pau, ext, ovl, swc, oov, otp, soff, son, spd, sov} = '0;
    {nto, ld} = '0;
    adr = 4'h0;
    wd = 32'h0000_0000;
    lv = 3'h0;
    trip = 12'h000;
    seed = 16'h0005;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("wait idle", 1'b1, wq);
    chk("gate rst", 1'b0, gate);
    chk("limit rst", 1'b1, fcl);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk("ctrl rst", 32'h0000_0001, q);
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    @(posedge clk);
    son <= 1'b1;
    step(3);
    chk("fresh step", 2'h0, ssp);
    state_is(2'h1);
    @(posedge clk);
    nto <= 1'b1;
    @(posedge clk);
    nto <= 1'b0;
    pulse_len();
    chk("max on", 1'b1, len >= 2995 && len <= 3005);
    chk("step 3", 2'h3, ssp);
    seed = lfsr(seed);
    @(posedge clk);
    ld <= 1'b1;
    lv <= (seed[2:0] == 3'h7) ? 3'h3 : seed[2:0];
    ent <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    step(EB + 10);
    chk("no entry count", 1'b0, bm);
    @(posedge clk);
    ld <= 1'b1;
    lv <= 3'h7;
    @(posedge clk);
    ld <= 1'b0;
    step(EB - 10);
    chk("entry early", 1'b0, bm);
    @(posedge clk);
    ent <= 1'b0;
    @(posedge clk);
    ent <= 1'b1;
    step(EB - 5);
    chk("entry broken", 1'b0, bm);
    wait_on(1, 1'b1, 20);
    chk("entry", 1'b1, bm);
    step(2);
    chk("paused bias", 1'b0, bias);
    @(posedge clk);
    res <= 1'b1;
    wait_on(2, 1'b1, 5);
    chk("resume bias", 1'b1, bias);
    pulse_len();
    chk("duty limit", 1'b1, len >= duty_cyc() - 3 && len <= duty_cyc() + 3);
    wait_on(0, 1'b1, 1923 - len - 12);
    chk("timer early", 1'b0, gate);
    wait_on(0, 1'b1, 25);
    chk("timer on", 1'b1, gate);
    @(posedge clk);
    trip <= 12'h064;
    otp <= 1'b1;
    ovl <= 1'b1;
    swc <= 1'b1;
    pulse_len();
    pulse_len();
    chk("current trip", 1'b1, len >= 99 && len <= 104);
    state_is(2'h1);
    @(posedge clk);
    {otp, ovl, swc} <= 3'h0;
    res <= 1'b0;
    pau <= 1'b1;
    wait_on(2, 1'b0, 5);
    chk("pause bias", 1'b0, bias);
    wait_on(0, 1'b1, 2500);
    chk("paused gate", 1'b0, gate);
    @(posedge clk);
    pau <= 1'b0;
    ent <= 1'b0;
    ext <= 1'b1;
    wait_on(1, 1'b0, 3);
    chk("exit", 1'b0, bm);
    step(2);
    chk("valley one", 3'h1, vc);
    chk("full limit", 1'b1, fcl);
    @(posedge clk);
    ext <= 1'b0;
    otp <= 1'b1;
    step(3);
    chk("otp gate", 1'b0, gate);
    state_is(2'h0);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk("cause ot", 32'h0000_0008, q);
    bus(1'b1, 4'h8, 32'h0000_003f);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk("cause clr", 32'h0000_0000, q);
    @(posedge clk);
    otp <= 1'b0;
    restart();
    chk("new soft start", 2'h0, ssp);
    bus(1'b1, 4'h0, 32'h0000_0000);
    @(posedge clk);
    nto <= 1'b1;
    step(3);
    chk("gate disabled", 1'b0, gate);
    @(posedge clk);
    nto <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_0001);
    @(posedge clk);
    sov <= 1'b1;
    step(500);
    state_is(2'h1);
    step(1010);
    state_is(2'h0);
    @(posedge clk);
    sov <= 1'b0;
    restart();
    @(posedge clk);
    nto <= 1'b1;
    @(posedge clk);
    nto <= 1'b0;
    wait_on(0, 1'b1, 20);
    @(posedge clk);
    swc <= 1'b1;
    step(30);
    state_is(2'h2);
    chk("latch gate", 1'b0, gate);
    @(posedge clk);
    swc <= 1'b0;
    otp <= 1'b1;
    restart();
    chk("startup off", 1'b0, sue);
    state_is(2'h2);
    @(posedge clk);
    spd <= 1'b1;
    otp <= 1'b0;
    step(3);
    state_is(2'h0);
    @(posedge clk);
    spd <= 1'b0;
    restart();
    @(posedge clk);
    // overload starts 20 cycles earlier so both faults mature on one edge
    ovl <= 1'b1;
    repeat (20) @(posedge clk);
    oov <= 1'b1;
    step(30);
    state_is(2'h1);
    step(20);
    state_is(2'h2);
    @(posedge clk);
    {oov, ovl, spd} <= 3'h1;
    step(3);
    @(posedge clk);
    spd <= 1'b0;
    restart();
    @(posedge clk);
    ovl <= 1'b1;
    step(40);
    state_is(2'h1);
    step(30);
    state_is(2'h0);
    finish_test();
  end
endmodule // tb_bmps_top
